// file: swd_cmd_unit.sv
// single-wire debug command unit: serial link, decoder, breakpoint
// Summary of operation
// - commands open with an 8-bit code; all fields go msb first
// - addresses 16 bits, byte data 8, word and match data 16 bits
// - non-intrusive commands always accepted; active ones only when halted
// - 0x90 halts the core unless permit-halt is clear
// - 0xe4 reads and 0xc4 writes the status/control register
// - 0xe0 reads a byte at an address; 0xe1 returns status first
// - 0xe8 re-reads the last read address, status then data
// - 0xc0 writes a byte; 0xc1 also returns status after delay
// - 0xe2 reads and 0xc2 loads the match register, no delay slot
// - 0xd5 and 0xd6 enable and disable the acknowledge handshake
// - 0x08 and 0x18 resume; 0x10 steps one instruction then halts
// - 0x68,0x69 read acc and flags; 0x6b,0x6c,0x6f read pc, index, sp
// - 0x48,0x49,0x4b,0x4c,0x4f write those core registers
// - 0x70 bumps index then reads there; 0x71 adds status first
// - 0x50 bumps index then writes there; 0x51 adds status after
// - sync reply: wait high, 16 cycles, 128 low, one high pulse
// - forced breakpoint halts after any access to the match address
// - tagged breakpoint halts only when the tagged opcode executes
// - no breakpoint while break enable is 0; select bit 1 is forced
// - control write keeps status bits; permit-halt fixed while halted
// - 16 cycles per bit; 512 cycles without a falling edge aborts
// - sample at cycle 10; a returned 0 is 13 low then speedup
`timescale 1ns/1ps
module swd_cmd_unit
	import swd_pkg::*;
(
	input wire logic clk, // debug clock
	input wire logic rst_n, // async reset, active low
	input wire logic debug_line_in, // debug line level from pin
	output logic debug_line_out, // level driven onto the line
	output logic debug_line_oe_n, // low while driving the line
	output swd_pkg::swd_req_t core_req, // access request to the core
	input wire swd_pkg::swd_rsp_t core_rsp, // access answer from the core
	input wire swd_pkg::swd_cpu_t cpu_stat, // core status
	output logic halt_req, // request entry to halted mode
	output logic resume_req, // pulse: run user program
	output logic step_req, // pulse: run one instruction
	output logic tag_mark, // tag the opcode being fetched
	output logic ack_enable, // acknowledge handshake enabled
	output logic debug_clock_select // clock select control bit
);
	import swd_pkg::*;

	typedef enum {
		SWD_ST_CMD, SWD_ST_ADDR, SWD_ST_WDATA, SWD_ST_EXEC, SWD_ST_WAIT,
		SWD_ST_SEND
	} swd_state_t;

	// line synchroniser; stage one feeds only stage two
	logic line_s1_r, line_s2_r, line_prev_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			line_s1_r <= 1'b1;
			line_s2_r <= 1'b1;
			line_prev_r <= 1'b1;
		end else begin
			line_s1_r <= debug_line_in;
			line_s2_r <= line_s1_r;
			line_prev_r <= line_s2_r;
		end
	end
	wire fall = line_prev_r & ~line_s2_r;

	// bit clock; counts from each host falling edge
	logic [SWD_CNT_W-1:0] bit_cnt_r, idle_cnt_r, low_cnt_r;
	logic in_bit_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt_r <= '0;
			in_bit_r <= 1'b0;
		end else if (fall) begin
			bit_cnt_r <= '0;
			in_bit_r <= 1'b1;
		end else if (in_bit_r) begin
			bit_cnt_r <= bit_cnt_r + 1'b1;
			if (bit_cnt_r == SWD_CNT_W'(SWD_LOW0_CYC + 1))
				in_bit_r <= 1'b0;
		end
	end
	wire sample = in_bit_r && bit_cnt_r == SWD_CNT_W'(SWD_BIT_SAMPLE - 1);

	// timeout between host falling edges
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			idle_cnt_r <= '0;
		else if (fall)
			idle_cnt_r <= '0;
		else if (idle_cnt_r != SWD_CNT_W'(SWD_TIMEOUT - 1))
			idle_cnt_r <= idle_cnt_r + 1'b1;
	end
	wire timeout = idle_cnt_r == SWD_CNT_W'(SWD_TIMEOUT - 2);

	// sync request: long host low, then wait for high, delay, reply
	logic sync_seen_r, sync_act_r;
	logic [7:0] sync_cnt_r;
	logic [1:0] sync_ph_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			low_cnt_r <= '0;
			sync_seen_r <= 1'b0;
		end else begin
			if (line_s2_r)
				low_cnt_r <= '0;
			else if (low_cnt_r != SWD_CNT_W'(SWD_SYNC_REQ))
				low_cnt_r <= low_cnt_r + 1'b1;
			// our own reply low must not retrigger a request
			if (sync_act_r)
				sync_seen_r <= 1'b0;
			else if (!line_s2_r && low_cnt_r == SWD_CNT_W'(SWD_SYNC_REQ))
				sync_seen_r <= 1'b1;
		end
	end
	// reply phases: 1 wait high while inactive, then delay; 2 low, 3 speedup
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_act_r <= 1'b0;
			sync_ph_r <= 2'h0;
			sync_cnt_r <= 8'h00;
		end else if (!sync_act_r) begin
			sync_act_r <= sync_seen_r & line_s2_r;
			sync_ph_r <= 2'h1;
			sync_cnt_r <= 8'h00;
		end else begin
			sync_cnt_r <= sync_cnt_r + 8'h01;
			case (sync_ph_r)
			2'h1: if (sync_cnt_r == 8'(SWD_SYNC_WAIT - 1)) begin
				sync_ph_r <= 2'h2;
				sync_cnt_r <= 8'h00;
			end
			2'h2: if (sync_cnt_r == 8'(SWD_SYNC_LOW - 1)) begin
				sync_ph_r <= 2'h3;
				sync_cnt_r <= 8'h00;
			end
			default: sync_act_r <= 1'b0;
			endcase
		end
	end

	// command engine state
	swd_state_t st_r;
	logic [7:0] cmd_r, ctrl_r;
	logic [15:0] sh_r, match_r, last_addr_r, rdata_r;
	logic [4:0] nbits_r;
	logic [5:0] tx_bits_r;
	logic [23:0] tx_r;
	logic [SWD_CNT_W-1:0] dly_r;
	logic tx_bit_r;

	wire is_active = cmd_r[7:6] == 2'b00 || cmd_r[7:4] == 4'h4
		|| cmd_r[7:4] == 4'h5 || cmd_r[7:4] == 4'h6 || cmd_r[7:4] == 4'h7;
	wire has_addr = cmd_r == SWD_CMD_RD_BYTE || cmd_r == SWD_CMD_RD_BYTE_F
		|| cmd_r == SWD_CMD_WR_BYTE || cmd_r == SWD_CMD_WR_BYTE_F;
	wire wide_in = cmd_r == SWD_CMD_WR_PC || cmd_r == SWD_CMD_WR_IDX
		|| cmd_r == SWD_CMD_WR_SP || cmd_r == SWD_CMD_WR_MATCH;
	wire has_wdata = cmd_r == SWD_CMD_WR_BYTE || cmd_r == SWD_CMD_WR_BYTE_F
		|| cmd_r[7:4] == 4'h4 || cmd_r[7:4] == 4'h5
		|| cmd_r == SWD_CMD_WR_CTRL || cmd_r == SWD_CMD_WR_MATCH;
	wire with_stat = cmd_r == SWD_CMD_RD_BYTE_F || cmd_r == SWD_CMD_RD_LAST
		|| cmd_r == SWD_CMD_WR_BYTE_F || cmd_r == SWD_CMD_RD_NEXT_F
		|| cmd_r == SWD_CMD_WR_NEXT_F;
	wire [15:0] idx_next = cpu_stat.idx + 16'h0001;
	wire [7:0] status = {ctrl_r[SWD_B_PERMIT], cpu_stat.halted,
		ctrl_r[5:3], cpu_stat.sleeping, ctrl_r[SWD_B_SLEEPF], 1'b0};

	// serial command sequencer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= SWD_ST_CMD;
			cmd_r <= 8'h00;
			sh_r <= 16'h0000;
			nbits_r <= 5'h00;
			tx_bits_r <= 6'h00;
			tx_r <= 24'h000000;
			dly_r <= '0;
			core_req <= '0;
			rdata_r <= 16'h0000;
			last_addr_r <= 16'h0000;
			tx_bit_r <= 1'b1;
		end else if (timeout || sync_seen_r || sync_act_r) begin
			st_r <= SWD_ST_CMD;
			nbits_r <= 5'h00;
			tx_bits_r <= 6'h00;
			core_req <= '0;
		end else begin
			core_req.mem_rd <= 1'b0;
			core_req.mem_wr <= 1'b0;
			core_req.reg_rd <= 1'b0;
			core_req.reg_wr <= 1'b0;
			// late answers still land; re-read data arrives during send
			if (core_rsp.done)
				rdata_r <= core_rsp.rdata;
			case (st_r)
			SWD_ST_CMD: if (sample) begin
				sh_r <= {sh_r[14:0], line_s2_r};
				nbits_r <= nbits_r + 5'h01;
				if (nbits_r == 5'd7) begin
					cmd_r <= {sh_r[6:0], line_s2_r};
					nbits_r <= 5'h00;
					st_r <= SWD_ST_EXEC;
				end
			end
			SWD_ST_EXEC: begin
				// route decoded command to its next field
				if (is_active && !cpu_stat.halted)
					st_r <= SWD_ST_CMD;
				else if (has_addr)
					st_r <= SWD_ST_ADDR;
				else if (has_wdata)
					st_r <= SWD_ST_WDATA;
				else
					st_r <= SWD_ST_WAIT;
				dly_r <= '0;
			end
			SWD_ST_ADDR: if (sample) begin
				sh_r <= {sh_r[14:0], line_s2_r};
				nbits_r <= nbits_r + 5'h01;
				if (nbits_r == 5'd15) begin
					core_req.addr <= {sh_r[14:0], line_s2_r};
					nbits_r <= 5'h00;
					st_r <= has_wdata ? SWD_ST_WDATA : SWD_ST_WAIT;
				end
			end
			SWD_ST_WDATA: if (sample) begin
				sh_r <= {sh_r[14:0], line_s2_r};
				nbits_r <= nbits_r + 5'h01;
				if (nbits_r == (wide_in ? 5'd15 : 5'd7)) begin
					core_req.wdata <= {sh_r[14:0], line_s2_r};
					nbits_r <= 5'h00;
					st_r <= SWD_ST_WAIT;
				end
			end
			SWD_ST_WAIT: begin
				// delay slot: issue access once, collect answer
				dly_r <= dly_r + 1'b1;
				if (dly_r == '0) begin
					case (cmd_r)
					SWD_CMD_RD_BYTE, SWD_CMD_RD_BYTE_F: begin
						core_req.mem_rd <= 1'b1;
						last_addr_r <= core_req.addr;
					end
					SWD_CMD_RD_LAST: begin
						core_req.mem_rd <= 1'b1;
						core_req.addr <= last_addr_r;
					end
					SWD_CMD_WR_BYTE, SWD_CMD_WR_BYTE_F:
						core_req.mem_wr <= 1'b1;
					SWD_CMD_RD_NEXT, SWD_CMD_RD_NEXT_F: begin
						core_req.mem_rd <= 1'b1;
						core_req.addr <= idx_next;
						last_addr_r <= idx_next;
					end
					SWD_CMD_WR_NEXT, SWD_CMD_WR_NEXT_F: begin
						core_req.mem_wr <= 1'b1;
						core_req.addr <= idx_next;
					end
					SWD_CMD_RD_ACC, SWD_CMD_RD_CCR, SWD_CMD_RD_PC,
					SWD_CMD_RD_IDX, SWD_CMD_RD_SP:
						core_req.reg_rd <= 1'b1;
					SWD_CMD_WR_ACC, SWD_CMD_WR_CCR, SWD_CMD_WR_PC,
					SWD_CMD_WR_IDX, SWD_CMD_WR_SP:
						core_req.reg_wr <= 1'b1;
					default: ;
					endcase
					case (cmd_r[3:0])
					4'h8: core_req.reg_sel <= SWD_REG_ACC;
					4'h9: core_req.reg_sel <= SWD_REG_CCR;
					4'hb: core_req.reg_sel <= SWD_REG_PC;
					4'hc: core_req.reg_sel <= SWD_REG_IDX;
					default: core_req.reg_sel <= SWD_REG_SP;
					endcase
				end
				// match, status and re-read commands have no delay slot
				if (cmd_r == SWD_CMD_RD_STAT || cmd_r == SWD_CMD_RD_MATCH
					|| cmd_r == SWD_CMD_RD_LAST
					|| cmd_r == SWD_CMD_WR_CTRL || cmd_r == SWD_CMD_WR_MATCH
					|| dly_r == SWD_CNT_W'(SWD_DELAY_SLOT - 1)) begin
					st_r <= SWD_ST_SEND;
				end
			end
			SWD_ST_SEND: begin
				// load reply once, then shift on each host bit
				if (tx_bits_r == 6'h00 && nbits_r == 5'h00) begin
					nbits_r <= 5'h01;
					case (cmd_r)
					SWD_CMD_RD_STAT: begin
						tx_r <= {status, 16'h0000};
						tx_bits_r <= 6'd8;
					end
					SWD_CMD_RD_MATCH: begin
						tx_r <= {match_r, 8'h00};
						tx_bits_r <= 6'd16;
					end
					SWD_CMD_RD_BYTE, SWD_CMD_RD_NEXT, SWD_CMD_RD_ACC,
					SWD_CMD_RD_CCR: begin
						tx_r <= {rdata_r[7:0], 16'h0000};
						tx_bits_r <= 6'd8;
					end
					SWD_CMD_RD_PC, SWD_CMD_RD_IDX, SWD_CMD_RD_SP: begin
						tx_r <= {rdata_r, 8'h00};
						tx_bits_r <= 6'd16;
					end
					SWD_CMD_RD_BYTE_F, SWD_CMD_RD_LAST, SWD_CMD_RD_NEXT_F: begin
						tx_r <= {status, rdata_r[7:0], 8'h00};
						tx_bits_r <= 6'd16;
					end
					SWD_CMD_WR_BYTE_F, SWD_CMD_WR_NEXT_F: begin
						tx_r <= {status, 16'h0000};
						tx_bits_r <= 6'd8;
					end
					default: begin
						nbits_r <= 5'h00;
						st_r <= SWD_ST_CMD;
					end
					endcase
				end else if (tx_bits_r == 6'h00) begin
					// hold until the last bit's drive is over
					if (!in_bit_r) begin
						nbits_r <= 5'h00;
						st_r <= SWD_ST_CMD;
					end
				end else if (fall) begin
					tx_bit_r <= tx_r[23];
					tx_bits_r <= tx_bits_r - 6'h01;
					// status gone: re-read data is in by now
					if (cmd_r == SWD_CMD_RD_LAST && tx_bits_r == 6'd9)
						tx_r <= {rdata_r[7:0], 16'h0000};
					else
						tx_r <= {tx_r[22:0], 1'b0};
				end
			end
			default: st_r <= SWD_ST_CMD;
			endcase
		end
	end
	wire fin = st_r == SWD_ST_WAIT && dly_r == SWD_CNT_W'(SWD_DELAY_SLOT - 1);
	wire fin_nd = st_r == SWD_ST_WAIT && dly_r == '0;

	// status/control register and breakpoint match register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= SWD_CTRL_RESET;
			match_r <= SWD_MATCH_RESET;
		end else begin
			if (fin_nd && cmd_r == SWD_CMD_WR_CTRL) begin
				if (!cpu_stat.halted)
					ctrl_r[SWD_B_PERMIT] <= core_req.wdata[SWD_B_PERMIT];
				ctrl_r[5:3] <= core_req.wdata[5:3];
			end
			if (fin_nd && cmd_r == SWD_CMD_WR_MATCH)
				match_r <= core_req.wdata;
			// sleep conflict is set by failed access; set wins
			if (core_rsp.done && core_rsp.fail)
				ctrl_r[SWD_B_SLEEPF] <= 1'b1;
			else if (fin && cmd_r == SWD_CMD_HALT)
				ctrl_r[SWD_B_SLEEPF] <= 1'b0;
		end
	end

	// run control, acknowledge mode and breakpoint
	wire brk_hit = ctrl_r[SWD_B_BRK_EN] && cpu_stat.addr_bus == match_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			halt_req <= 1'b0;
			resume_req <= 1'b0;
			step_req <= 1'b0;
			tag_mark <= 1'b0;
			ack_enable <= 1'b0;
			debug_clock_select <= 1'b0;
		end else begin
			resume_req <= fin && (cmd_r == SWD_CMD_GO
				|| cmd_r == SWD_CMD_GO_TAG);
			step_req <= fin && cmd_r == SWD_CMD_STEP;
			tag_mark <= brk_hit && !ctrl_r[SWD_B_FTS] && cpu_stat.fetch;
			debug_clock_select <= ctrl_r[SWD_B_CLKSEL];
			if (fin && cmd_r == SWD_CMD_HALT && ctrl_r[SWD_B_PERMIT])
				halt_req <= 1'b1;
			else if (brk_hit && ctrl_r[SWD_B_FTS] && !cpu_stat.halted)
				halt_req <= 1'b1;
			else if (cpu_stat.halted)
				halt_req <= 1'b0;
			if (fin && cmd_r == SWD_CMD_ACK_ON)
				ack_enable <= 1'b1;
			else if (fin && cmd_r == SWD_CMD_ACK_OFF)
				ack_enable <= 1'b0;
		end
	end

	// line driver: returned bits and sync reply
	wire tx_on = st_r == SWD_ST_SEND && in_bit_r && nbits_r != 5'h00;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			debug_line_out <= 1'b1;
			debug_line_oe_n <= 1'b1;
		end else if (sync_act_r && sync_ph_r != 2'h1) begin
			debug_line_out <= sync_ph_r == 2'h3;
			debug_line_oe_n <= 1'b0;
		end else if (tx_on && !tx_bit_r && bit_cnt_r < SWD_CNT_W'(SWD_LOW0_CYC)) begin
			debug_line_out <= 1'b0;
			debug_line_oe_n <= 1'b0;
		end else if (tx_on && (tx_bit_r ? bit_cnt_r == SWD_CNT_W'(SWD_SPEEDUP_AT)
			: bit_cnt_r == SWD_CNT_W'(SWD_LOW0_CYC))) begin
			debug_line_out <= 1'b1;
			debug_line_oe_n <= 1'b0;
		end else begin
			debug_line_out <= 1'b1;
			debug_line_oe_n <= 1'b1;
		end
	end

endmodule : swd_cmd_unit

// file: swd_pkg.sv
// package for the single-wire debug command unit
package swd_pkg;

	// serial bit timing, in debug clock cycles
	localparam int unsigned SWD_BIT_SAMPLE = 10;
	localparam int unsigned SWD_LOW0_CYC = 13;
	localparam int unsigned SWD_SPEEDUP_AT = 7;
	localparam int unsigned SWD_DELAY_SLOT = 16;
	localparam int unsigned SWD_TIMEOUT = 512;
	localparam int unsigned SWD_SYNC_REQ = 128;
	localparam int unsigned SWD_SYNC_WAIT = 16;
	localparam int unsigned SWD_SYNC_LOW = 128;
	localparam int unsigned SWD_CNT_W = 10;

	// command codes
	localparam logic [7:0] SWD_CMD_ACK_ON = 8'hd5;
	localparam logic [7:0] SWD_CMD_ACK_OFF = 8'hd6;
	localparam logic [7:0] SWD_CMD_HALT = 8'h90;
	localparam logic [7:0] SWD_CMD_RD_STAT = 8'he4;
	localparam logic [7:0] SWD_CMD_WR_CTRL = 8'hc4;
	localparam logic [7:0] SWD_CMD_RD_BYTE = 8'he0;
	localparam logic [7:0] SWD_CMD_RD_BYTE_F = 8'he1;
	localparam logic [7:0] SWD_CMD_RD_LAST = 8'he8;
	localparam logic [7:0] SWD_CMD_WR_BYTE = 8'hc0;
	localparam logic [7:0] SWD_CMD_WR_BYTE_F = 8'hc1;
	localparam logic [7:0] SWD_CMD_RD_MATCH = 8'he2;
	localparam logic [7:0] SWD_CMD_WR_MATCH = 8'hc2;
	localparam logic [7:0] SWD_CMD_GO = 8'h08;
	localparam logic [7:0] SWD_CMD_GO_TAG = 8'h18;
	localparam logic [7:0] SWD_CMD_STEP = 8'h10;
	localparam logic [7:0] SWD_CMD_RD_ACC = 8'h68;
	localparam logic [7:0] SWD_CMD_RD_CCR = 8'h69;
	localparam logic [7:0] SWD_CMD_RD_PC = 8'h6b;
	localparam logic [7:0] SWD_CMD_RD_IDX = 8'h6c;
	localparam logic [7:0] SWD_CMD_RD_SP = 8'h6f;
	localparam logic [7:0] SWD_CMD_RD_NEXT = 8'h70;
	localparam logic [7:0] SWD_CMD_RD_NEXT_F = 8'h71;
	localparam logic [7:0] SWD_CMD_WR_ACC = 8'h48;
	localparam logic [7:0] SWD_CMD_WR_CCR = 8'h49;
	localparam logic [7:0] SWD_CMD_WR_PC = 8'h4b;
	localparam logic [7:0] SWD_CMD_WR_IDX = 8'h4c;
	localparam logic [7:0] SWD_CMD_WR_SP = 8'h4f;
	localparam logic [7:0] SWD_CMD_WR_NEXT = 8'h50;
	localparam logic [7:0] SWD_CMD_WR_NEXT_F = 8'h51;

	// debug_status_control bit positions
	localparam int unsigned SWD_B_PERMIT = 7;
	localparam int unsigned SWD_B_HALT = 6;
	localparam int unsigned SWD_B_BRK_EN = 5;
	localparam int unsigned SWD_B_FTS = 4;
	localparam int unsigned SWD_B_CLKSEL = 3;
	localparam int unsigned SWD_B_SLEEP = 2;
	localparam int unsigned SWD_B_SLEEPF = 1;
	localparam int unsigned SWD_B_SLOWF = 0;
	localparam logic [7:0] SWD_CTRL_RESET = 8'h00;
	localparam logic [15:0] SWD_MATCH_RESET = 16'h0000;

	// cpu register selectors on the debug access port
	typedef enum logic [2:0] {
		SWD_REG_ACC, SWD_REG_CCR, SWD_REG_PC, SWD_REG_IDX, SWD_REG_SP
	} swd_reg_t;

	// request from the command unit to the core
	typedef struct packed {
		logic mem_rd;
		logic mem_wr;
		logic reg_rd;
		logic reg_wr;
		swd_reg_t reg_sel;
		logic [15:0] addr;
		logic [15:0] wdata;
	} swd_req_t;

	// answer from the core; done is a one-cycle pulse
	typedef struct packed {
		logic done;
		logic fail;
		logic [15:0] rdata;
	} swd_rsp_t;

	// cpu status seen by the command unit
	typedef struct packed {
		logic halted;
		logic sleeping;
		logic [15:0] addr_bus;
		logic fetch;
		logic [15:0] idx;
	} swd_cpu_t;

endpackage : swd_pkg

// file: swd_cmd_unit_sva.sv
// port assertions for the debug command unit
`timescale 1ns/1ps
module swd_cmd_unit_chk
	import swd_pkg::*;
(
	input wire logic clk, // debug clock
	input wire logic rst_n, // async reset, active low
	input wire logic debug_line_out, // driven level
	input wire logic debug_line_oe_n, // low while driving
	input wire swd_pkg::swd_req_t core_req, // core access request
	input wire swd_pkg::swd_cpu_t cpu_stat, // core status
	input wire logic halt_req, // halt request level
	input wire logic resume_req, // run pulse
	input wire logic step_req // step pulse
);
	logic drv0;
	logic [7:0] low_r;
	// device pulling the line low
	assign drv0 = !debug_line_oe_n && !debug_line_out;
	// length of the current low drive, saturating so it never wraps
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			low_r <= 8'h00;
		end else if (!drv0) begin
			low_r <= 8'h00;
		end else if (low_r != 8'hff) begin
			low_r <= low_r + 8'h01;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_low_len;
		!drv0 && low_r != 8'h00 |-> low_r == 8'h0d || low_r == 8'h80;
	endproperty
	property p_speedup;
		drv0 ##1 !drv0 |-> !debug_line_oe_n && debug_line_out;
	endproperty
	property p_release;
		!debug_line_oe_n && debug_line_out |=> debug_line_oe_n;
	endproperty
	property p_req_excl;
		$onehot0({core_req.mem_rd, core_req.mem_wr, core_req.reg_rd,
			core_req.reg_wr});
	endproperty
	property p_req_pulse;
		core_req.mem_rd || core_req.mem_wr |=>
			!core_req.mem_rd && !core_req.mem_wr;
	endproperty
	property p_reg_halted;
		core_req.reg_rd || core_req.reg_wr |-> cpu_stat.halted;
	endproperty
	property p_run_halted;
		resume_req || step_req |->
			$past(cpu_stat.halted) && !(resume_req && step_req);
	endproperty
	property p_halt_clear;
		halt_req && cpu_stat.halted |-> ##[0:2] !halt_req;
	endproperty
	a_low_len: assert property (p_low_len) else $error("bad low time");
	a_speedup: assert property (p_speedup) else $error("no speedup");
	a_release: assert property (p_release) else $error("no release");
	a_req_excl: assert property (p_req_excl) else $error("mixed req");
	a_req_pulse: assert property (p_req_pulse) else $error("long req");
	a_reg_halted: assert property (p_reg_halted) else $error("reg run");
	a_run_halted: assert property (p_run_halted) else $error("bad run");
	a_halt_clear: assert property (p_halt_clear) else $error("halt stuck");
	c_sync: cover property (low_r == 8'h80);
	c_run: cover property (resume_req);
	c_wr: cover property (core_req.mem_wr);
endmodule : swd_cmd_unit_chk

// file: swd_host.sv
// debug host pod model: makes every falling edge on the debug line except the start of the sync reply low
`timescale 1ns/1ps
module swd_host (
	input wire logic clk, // debug clock
	input wire logic line, // resolved line level
	output logic host_low // host pulls line low
);
	initial host_low = 1'b0;
	// one host bit per falling edge, msb first; a 0 is held past sampling
	task automatic send(input int n, input logic [15:0] d);
		for (int i = n - 1; i >= 0; i--) begin
			@(negedge clk) host_low <= 1'b1;
			repeat (d[i] ? 4 : 15) @(negedge clk);
			host_low <= 1'b0;
			repeat (d[i] ? 14 : 3) @(negedge clk);
		end
	endtask : send
	// short low starts each bit, then released before the speedup
	task automatic recv(input int n, output logic [15:0] d);
		d = 16'h0000;
		for (int i = n - 1; i >= 0; i--) begin
			@(negedge clk) host_low <= 1'b1;
			// held past the device's synchronised start of drive
			repeat (5) @(negedge clk);
			host_low <= 1'b0;
			repeat (7) @(negedge clk);
			d[i] = line;
			repeat (9) @(negedge clk);
		end
	endtask : recv
	// delay slot with margin over 16 cycles
	task automatic gap();
		repeat (20) @(negedge clk);
	endtask : gap
	// long low request, then measure the reply low time
	task automatic sync(output int len);
		len = 0;
		@(negedge clk) host_low <= 1'b1;
		repeat (140) @(negedge clk);
		host_low <= 1'b0;
		// let our own release reach the line before watching it
		@(negedge clk);
		for (int i = 0; i < 60 && line; i++) @(negedge clk);
		while (!line && len < 300) begin
			@(negedge clk);
			len++;
		end
	endtask : sync
endmodule : swd_host

// file: tb_swd_cmd_unit.sv
// self-checking bench for the debug command unit
`timescale 1ns/1ps
module tb_swd_cmd_unit;
	import swd_pkg::*;
	logic clk, rst_n, debug_line_out, debug_line_oe_n, host_low, debug_line;
	logic halt_req, resume_req, step_req, tag_mark, ack_enable, clk_sel;
	swd_req_t core_req;
	swd_rsp_t core_rsp;
	swd_cpu_t cpu_stat;
	logic [15:0] wr_addr, rd_addr, v;
	logic [7:0] wr_data;
	int wait_c, n_run, n_regwr, bad_count, samples_checked, len;
	// pull-up wins unless someone drives low
	assign debug_line = !host_low && !(!debug_line_oe_n && !debug_line_out);
	swd_cmd_unit swd_cmd_unit_i (.clk(clk), .rst_n(rst_n),
		.debug_line_in(debug_line), .debug_line_out(debug_line_out),
		.debug_line_oe_n(debug_line_oe_n), .core_req(core_req),
		.core_rsp(core_rsp), .cpu_stat(cpu_stat), .halt_req(halt_req),
		.resume_req(resume_req), .step_req(step_req), .tag_mark(tag_mark),
		.ack_enable(ack_enable), .debug_clock_select(clk_sel));
	swd_host swd_host_i (.clk(clk), .line(debug_line), .host_low(host_low));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// core stand-in: answers each access three cycles later
	always @(negedge clk) begin
		core_rsp.done <= (wait_c == 1);
		if (wait_c != 0) wait_c <= wait_c - 1;
		if (|{core_req.mem_rd, core_req.mem_wr, core_req.reg_rd,
			core_req.reg_wr}) begin
			wait_c <= 3;
			core_rsp.rdata <= core_req.mem_rd ?
				{8'h00, core_req.addr[7:0] ^ 8'h3c} : {13'h17c0, core_req.reg_sel};
		end
		if (core_req.mem_rd) rd_addr <= core_req.addr;
		if (core_req.mem_wr) wr_addr <= core_req.addr;
		if (core_req.mem_wr) wr_data <= core_req.wdata[7:0];
		if (core_req.reg_wr) n_regwr <= n_regwr + 1;
		if (resume_req) n_run <= n_run + 1;
		if (resume_req) cpu_stat.halted <= 1'b0;
		if (halt_req) cpu_stat.halted <= 1'b1;
	end
	task automatic chk(input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic rd_stat(input logic [7:0] exp);
		swd_host_i.send(8, {8'h00, SWD_CMD_RD_STAT});
		swd_host_i.recv(8, v);
		chk({8'h00, exp}, v);
	endtask : rd_stat
	task automatic wr_ctrl(input logic [7:0] d);
		swd_host_i.send(8, {8'h00, SWD_CMD_WR_CTRL});
		swd_host_i.send(8, {8'h00, d});
	endtask : wr_ctrl
	task automatic wait_halt();
		for (int i = 0; i < 20 && cpu_stat.halted !== 1'b1; i++) @(negedge clk);
		chk(16'h0001, {15'h0000, cpu_stat.halted});
	endtask : wait_halt
	task automatic t_reset();
		chk(16'h0001, {15'h0000, debug_line_oe_n});
		chk(16'h0000, {15'h0000, clk_sel});
		rd_stat(SWD_CTRL_RESET);
		$display("test reset done");
	endtask : t_reset
	task automatic t_ctrl();
		wr_ctrl(8'hff);
		rd_stat(8'hb8);
		chk(16'h0001, {15'h0000, clk_sel});
		$display("test control done");
	endtask : t_ctrl
	task automatic t_mem();
		swd_host_i.send(8, {8'h00, SWD_CMD_RD_BYTE});
		swd_host_i.send(16, 16'h1234);
		swd_host_i.gap();
		swd_host_i.recv(8, v);
		chk(16'h0008, v);
		chk(16'h1234, rd_addr);
		swd_host_i.send(8, {8'h00, SWD_CMD_RD_LAST});
		swd_host_i.recv(8, v);
		chk(16'h00b8, v);
		swd_host_i.recv(8, v);
		chk(16'h0008, v);
		swd_host_i.send(8, {8'h00, SWD_CMD_WR_BYTE_F});
		swd_host_i.send(16, 16'h4321);
		swd_host_i.send(8, 16'h0077);
		swd_host_i.gap();
		swd_host_i.recv(8, v);
		chk(16'h00b8, v);
		chk(16'h4321, wr_addr);
		chk(16'h0077, {8'h00, wr_data});
		$display("test memory done");
	endtask : t_mem
	task automatic t_match();
		swd_host_i.send(8, {8'h00, SWD_CMD_WR_MATCH});
		swd_host_i.send(16, 16'ha55a);
		swd_host_i.send(8, {8'h00, SWD_CMD_RD_MATCH});
		swd_host_i.recv(16, v);
		chk(16'ha55a, v);
		@(negedge clk) cpu_stat.addr_bus = 16'ha55a;
		@(negedge clk) cpu_stat.addr_bus = 16'hffff;
		wait_halt();
		$display("test breakpoint done");
	endtask : t_match
	task automatic t_active();
		rd_stat(8'hf8);
		wr_ctrl(8'h00);
		rd_stat(8'hc0);
		swd_host_i.send(8, {8'h00, SWD_CMD_RD_PC});
		swd_host_i.gap();
		swd_host_i.recv(16, v);
		chk({13'h17c0, SWD_REG_PC}, v);
		swd_host_i.send(8, {8'h00, SWD_CMD_GO});
		swd_host_i.gap();
		chk(16'h0001, n_run[15:0]);
		swd_host_i.send(8, {8'h00, SWD_CMD_ACK_ON});
		swd_host_i.gap();
		chk(16'h0001, {15'h0000, ack_enable});
		swd_host_i.send(8, {8'h00, SWD_CMD_ACK_OFF});
		swd_host_i.gap();
		chk(16'h0000, {15'h0000, ack_enable});
		$display("test active done");
	endtask : t_active
	task automatic t_ignore();
		swd_host_i.send(8, {8'h00, SWD_CMD_WR_ACC});
		swd_host_i.send(8, 16'h0011);
		swd_host_i.gap();
		chk(16'h0000, n_regwr[15:0]);
		rd_stat(8'h80);
		swd_host_i.send(8, {8'h00, SWD_CMD_HALT});
		swd_host_i.gap();
		wait_halt();
		swd_host_i.sync(len);
		chk(16'h0080, len[15:0]);
		$display("test ignore and sync done");
	endtask : t_ignore
	initial begin
		rst_n = 1'b0;
		core_rsp = '0;
		cpu_stat = '0;
		cpu_stat.addr_bus = 16'hffff;
		cpu_stat.idx = 16'h0100;
		{wait_c, n_run, n_regwr, bad_count, samples_checked} = '0;
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		repeat (5) @(negedge clk);
		t_reset();
		t_ctrl();
		t_mem();
		t_match();
		t_active();
		t_ignore();
		report_and_stop();
	end
	// a hang is cut short and counted as a mismatch
	initial begin
		#1000000;
		bad_count++;
		report_and_stop();
	end
endmodule : tb_swd_cmd_unit
bind swd_cmd_unit swd_cmd_unit_chk swd_cmd_unit_chk_i (.clk(clk),
	.rst_n(rst_n), .debug_line_out(debug_line_out),
	.debug_line_oe_n(debug_line_oe_n), .core_req(core_req),
	.cpu_stat(cpu_stat), .halt_req(halt_req), .resume_req(resume_req),
	.step_req(step_req));
